// ===== pkg/clock_mux_pkg.sv
// constants and state codes for the glitchless clock switchover mux
// assumes one sampling clock, mclk, far faster than both clock inputs
package clock_mux_pkg;
   // sampling clock
   localparam int MCLK_PERIOD_NS = 4;
   // input synchroniser: pin bit positions
   localparam int SYNC_WIDTH = 6;
   localparam int PIN_CLK_A = 0;
   localparam int PIN_CLK_B = 1;
   localparam int PIN_SELECT = 2;
   localparam int PIN_LOST_A = 3;
   localparam int PIN_LOST_B = 4;
   localparam int PIN_POR_CAP = 5;
   // cycles after reset release before the strap and select are trusted
   localparam logic [2:0] POR_SETTLE_CYCLES = 3'h5;
   // target rising edges that a stuck-high current clock is kept high
   localparam logic [3:0] STUCK_HIGH_EDGES = 4'h3;
   // target falling edges the output is held low before following
   localparam logic [3:0] LOW_HOLD_EDGES = 4'h2;
   // worst-case target cycles from select change to settled output
   localparam int SWITCH_MAX_EDGES = 17;
   localparam logic [3:0] EDGE_COUNT_ZERO = 4'h0;
   localparam logic [3:0] EDGE_COUNT_ONE = 4'h1;
   localparam logic [2:0] SETTLE_ZERO = 3'h0;
   localparam logic [2:0] SETTLE_ONE = 3'h1;
   // switchover sequence states
   typedef enum logic [1:0] {
      ST_FOLLOW = 2'b00,
      ST_WAIT_LOW = 2'b01,
      ST_HOLD_LOW = 2'b10
   } switch_state_t;
endpackage

// ===== rtl/pin_sync.sv
// three-flop synchroniser with agreement filter for asynchronous pins
// assumes pins change slowly against mclk; reset is asynchronous
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // pins and filtered result
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_sync_out;

   // a bit counts only once the second and third flops agree
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] :
                            sync_out[i];
      end
   end

   // first flop feeds only the second one
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta <= async_in;
         stage2 <= meta;
         stage3 <= stage2;
         sync_out <= next_sync_out;
      end
   end
endmodule // pin_sync

// ===== rtl/glitchless_clock_switchover_mux.sv
// two-input clock selector with staged, runt-free switchover
// assumes clock inputs are sampled by mclk at a far higher rate
// Notes on behaviour
// RQ1: select low picks input a, high b
// RQ2: staged switch settles within seventeen target cycles
// RQ3: protection off means immediate switch
// RQ4: strap tied high disables protection, plain selector
// RQ5: same sequence either direction
// RQ6: collapsed selected input freezes output level
// RQ7: sources stay within 1.5 to 1 ratio
// RQ8: follow current, hold low, then follow target
// RQ9: stuck high: stay high, go low, follow
// RQ10: stretched cycle phases exceed half target period
// RQ11: select synchronised, stage counts may vary
// RQ12: reset gives known state before select honoured
`timescale 1ns/100ps
module glitchless_clock_switchover_mux (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // clock sources and amplitude detectors
   input wire logic clock_input_a,
   input wire logic clock_input_b,
   input wire logic amplitude_lost_a,
   input wire logic amplitude_lost_b,
   // selection and strap
   input wire logic input_select,
   input wire logic por_capacitor_pin,
   // output clock and status
   output logic clock_out,
   output logic active_select,
   output logic glitchless_switch,
   output logic amplitude_loss_hold,
   output logic switch_busy
);
   logic [clock_mux_pkg::SYNC_WIDTH-1:0] pins;
   logic [clock_mux_pkg::SYNC_WIDTH-1:0] pins_s;
   logic a_s, b_s, sel_s, lost_a_s, lost_b_s, bypass_s;
   logic prev_a, prev_b, next_prev_a, next_prev_b;
   clock_mux_pkg::switch_state_t state, next_state;
   logic [3:0] edge_count, next_edge_count;
   logic [2:0] settle, next_settle;
   logic started;
   logic next_out, next_active, next_glitchless, next_hold, next_busy;
   logic cur_s, tgt_s, cur_lost, tgt_lost, tgt_rise, tgt_fall, hold_now;

   // every pin crosses into mclk through the same filter
   assign pins = {por_capacitor_pin, amplitude_lost_b, amplitude_lost_a,
                  input_select, clock_input_b, clock_input_a};

   pin_sync #(
      .WIDTH(clock_mux_pkg::SYNC_WIDTH)
   ) u_pin_sync (
      .mclk(mclk),
      .rstn(rstn),
      .async_in(pins),
      .sync_out(pins_s)
   ); // RQ11

   // unpack filtered pins
   assign a_s = pins_s[clock_mux_pkg::PIN_CLK_A];
   assign b_s = pins_s[clock_mux_pkg::PIN_CLK_B];
   assign sel_s = pins_s[clock_mux_pkg::PIN_SELECT];
   assign lost_a_s = pins_s[clock_mux_pkg::PIN_LOST_A];
   assign lost_b_s = pins_s[clock_mux_pkg::PIN_LOST_B];
   assign bypass_s = pins_s[clock_mux_pkg::PIN_POR_CAP];
   assign started = (settle == clock_mux_pkg::POR_SETTLE_CYCLES);

   // one mapping for both directions, so either input may be primary
   assign cur_s = active_select ? b_s : a_s; // RQ5
   assign tgt_s = active_select ? a_s : b_s; // RQ5
   assign cur_lost = active_select ? lost_b_s : lost_a_s;
   assign tgt_lost = active_select ? lost_a_s : lost_b_s;
   assign tgt_rise = tgt_s && !(active_select ? prev_a : prev_b);
   assign tgt_fall = !tgt_s && (active_select ? prev_a : prev_b);
   // freeze only while the driving source has collapsed
   assign hold_now = started && (state == clock_mux_pkg::ST_FOLLOW) &&
                     (bypass_s ? (sel_s ? lost_b_s : lost_a_s) : cur_lost);

   // switchover sequence and output selection
   always_comb
   begin
      next_state = state;
      next_edge_count = edge_count;
      next_active = active_select;
      next_out = clock_out;
      next_settle = started ? settle : settle + clock_mux_pkg::SETTLE_ONE;
      next_prev_a = a_s;
      next_prev_b = b_s;
      next_glitchless = started ? !bypass_s : glitchless_switch; // RQ4
      next_hold = hold_now;
      if (!started)
      begin
         // held quiet until the strap and select have settled
         next_out = 1'b0; // RQ12
      end
      else if (bypass_s)
      begin
         // plain selector: no stages, new input at once
         next_state = clock_mux_pkg::ST_FOLLOW; // RQ3 RQ4
         next_active = sel_s; // RQ1 RQ3
         if (!hold_now)
            next_out = sel_s ? b_s : a_s; // RQ1
      end
      else
      begin
         case (state)
            clock_mux_pkg::ST_FOLLOW:
            begin
               if (!hold_now)
                  next_out = cur_s; // RQ1 RQ6
               if (sel_s != active_select)
               begin
                  next_state = clock_mux_pkg::ST_WAIT_LOW; // RQ8
                  next_edge_count = clock_mux_pkg::EDGE_COUNT_ZERO;
               end
            end
            clock_mux_pkg::ST_WAIT_LOW:
            begin
               // keep following current until it falls of itself
               if (!cur_s && !cur_lost)
               begin
                  next_out = 1'b0; // RQ8
                  next_state = clock_mux_pkg::ST_HOLD_LOW;
                  next_edge_count = clock_mux_pkg::EDGE_COUNT_ZERO;
               end
               else if (edge_count == clock_mux_pkg::STUCK_HIGH_EDGES) // RQ2
               begin
                  // current stuck or dead: give up after target edges
                  next_out = 1'b0; // RQ9
                  next_state = clock_mux_pkg::ST_HOLD_LOW;
                  next_edge_count = clock_mux_pkg::EDGE_COUNT_ZERO;
               end
               else
               begin
                  if (!cur_lost)
                     next_out = cur_s; // RQ8
                  if (tgt_rise)
                     next_edge_count = edge_count +
                                       clock_mux_pkg::EDGE_COUNT_ONE; // RQ9
               end
            end
            clock_mux_pkg::ST_HOLD_LOW:
            begin
               next_out = 1'b0; // RQ8 RQ9
               // leave only with target low so its next high is whole
               if (edge_count == clock_mux_pkg::LOW_HOLD_EDGES && !tgt_s)
               begin
                  next_state = clock_mux_pkg::ST_FOLLOW; // RQ10
                  next_active = !active_select; // RQ5
               end
               else if (tgt_fall && !tgt_lost)
                  next_edge_count = edge_count +
                                    clock_mux_pkg::EDGE_COUNT_ONE; // RQ10
            end
            default:
            begin
               next_state = clock_mux_pkg::ST_FOLLOW;
               next_out = 1'b0;
            end
         endcase
      end
      next_busy = (next_state != clock_mux_pkg::ST_FOLLOW);
   end

   // state registers; all outputs leave straight from here
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= clock_mux_pkg::ST_FOLLOW; // RQ12
         edge_count <= clock_mux_pkg::EDGE_COUNT_ZERO;
         settle <= clock_mux_pkg::SETTLE_ZERO;
         prev_a <= 1'b0;
         prev_b <= 1'b0;
         clock_out <= 1'b0;
         active_select <= 1'b0;
         glitchless_switch <= 1'b0;
         amplitude_loss_hold <= 1'b0;
         switch_busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         edge_count <= next_edge_count;
         settle <= next_settle;
         prev_a <= next_prev_a;
         prev_b <= next_prev_b;
         clock_out <= next_out;
         active_select <= next_active;
         glitchless_switch <= next_glitchless;
         amplitude_loss_hold <= next_hold;
         switch_busy <= next_busy;
      end
   end

   // helper: target rising edges seen during one switchover
   localparam int SW_MAX = clock_mux_pkg::SWITCH_MAX_EDGES;
   logic [4:0] sw_edges;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         sw_edges <= 5'h00;
      else if (state == clock_mux_pkg::ST_FOLLOW)
         sw_edges <= 5'h00;
      else if (tgt_rise && sw_edges != 5'h1F)
         sw_edges <= sw_edges + 5'h01;
   end

   sequence s_enter_low;
      state == clock_mux_pkg::ST_WAIT_LOW ##1
      state == clock_mux_pkg::ST_HOLD_LOW;
   endsequence
   sequence s_switch_done;
      state == clock_mux_pkg::ST_HOLD_LOW ##1
      state == clock_mux_pkg::ST_FOLLOW;
   endsequence

   property p_follow;
      @(posedge mclk) disable iff (!rstn)
      (started && !bypass_s && !hold_now &&
       state == clock_mux_pkg::ST_FOLLOW)
      |=> clock_out == $past(cur_s);
   endproperty
   a_follow: assert property (p_follow) // RQ1
      else $error("output not following active input");

   property p_settle;
      @(posedge mclk) disable iff (!rstn)
      sw_edges <= SW_MAX;
   endproperty
   a_settle: assert property (p_settle) // RQ2
      else $error("switchover took too many target cycles");

   property p_bypass;
      @(posedge mclk) disable iff (!rstn)
      (started && bypass_s) |=> (active_select == $past(sel_s)) &&
      !switch_busy && !glitchless_switch;
   endproperty
   a_bypass: assert property (p_bypass) // RQ3 RQ4
      else $error("plain selector did not switch at once");

   property p_symmetric;
      @(posedge mclk) disable iff (!rstn)
      s_switch_done |-> active_select != $past(active_select);
   endproperty
   a_symmetric: assert property (p_symmetric) // RQ5
      else $error("switchover did not swap the active input");

   property p_hold;
      @(posedge mclk) disable iff (!rstn)
      hold_now |=> $stable(clock_out) && amplitude_loss_hold;
   endproperty
   a_hold: assert property (p_hold) // RQ6
      else $error("output moved while source collapsed");

   property p_low_stage;
      @(posedge mclk) disable iff (!rstn)
      s_enter_low |-> !clock_out ##1 !clock_out;
   endproperty
   a_low_stage: assert property (p_low_stage) // RQ8
      else $error("output not low in hold stage");

   property p_stuck;
      @(posedge mclk) disable iff (!rstn)
      (started && !bypass_s && state == clock_mux_pkg::ST_WAIT_LOW &&
       edge_count == clock_mux_pkg::STUCK_HIGH_EDGES)
      |=> state == clock_mux_pkg::ST_HOLD_LOW && !clock_out;
   endproperty
   a_stuck: assert property (p_stuck) // RQ9
      else $error("stuck-high current not abandoned");

   property p_low_phase;
      @(posedge mclk) disable iff (!rstn)
      s_switch_done |->
      $past(edge_count) == clock_mux_pkg::LOW_HOLD_EDGES && !clock_out;
   endproperty
   a_low_phase: assert property (p_low_phase) // RQ10
      else $error("low phase left too early");

   property p_por;
      @(posedge mclk) disable iff (!rstn)
      !started |=> !clock_out && !active_select &&
      state == clock_mux_pkg::ST_FOLLOW;
   endproperty
   a_por: assert property (p_por) // RQ12
      else $error("state not known before settle");
endmodule // glitchless_clock_switchover_mux

// ===== verif/clock_source_pair.sv
// far-side model: two free-running clock sources feeding the mux
// assumes the bench raises stuck_a to model a source failed high
`timescale 1ns/100ps
module clock_source_pair #(
   parameter int HALF_A_NS = 20,
   parameter int HALF_B_NS = 24
) (
   // fault control from the bench
   input wire logic stuck_a,
   // clock sources
   output logic clock_input_a,
   output logic clock_input_b
);
   // source a; a failed source parks high instead of toggling
   initial
   begin
      clock_input_a = 1'b0;
      forever
      begin
         #(HALF_A_NS) clock_input_a = stuck_a ? 1'b1 : ~clock_input_a;
      end
   end

   // source b, odd offset keeps its phase unrelated to a and mclk
   initial
   begin
      clock_input_b = 1'b0;
      #7.3;
      forever
      begin
         #(HALF_B_NS) clock_input_b = ~clock_input_b;
      end
   end
endmodule // clock_source_pair

// ===== verif/tb_top.sv
// bench for the switchover mux with a queue-based reference of sources
// assumes clock_source_pair and the mux design are compiled beforehand
`timescale 1ns/100ps
module tb_top;
   logic mclk, rstn, stuck_a, lost_a, lost_b, sel, strap;
   logic clock_input_a, clock_input_b;
   logic clock_out, active_select, glitchless_switch, hold, busy;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   int ha[$];
   int hb[$];

   // far-side sources: a half period 5 mclk, b half period 6 mclk
   clock_source_pair src (
      .stuck_a(stuck_a),
      .clock_input_a(clock_input_a),
      .clock_input_b(clock_input_b)
   );

   glitchless_clock_switchover_mux dut (
      .mclk(mclk), .rstn(rstn),
      .clock_input_a(clock_input_a), .clock_input_b(clock_input_b),
      .amplitude_lost_a(lost_a), .amplitude_lost_b(lost_b),
      .input_select(sel), .por_capacitor_pin(strap),
      .clock_out(clock_out), .active_select(active_select),
      .glitchless_switch(glitchless_switch),
      .amplitude_loss_hold(hold), .switch_busy(busy)
   );

   // 250 MHz sampling clock
   initial
   begin
      mclk = 1'b0;
      forever
      begin
         #2 mclk = ~mclk;
      end
   end

   // reference history of both sources, plus hang guard
   always @(posedge mclk)
   begin
      ha.push_front(int'(clock_input_a));
      hb.push_front(int'(clock_input_b));
      if (ha.size() > 8)
      begin
         void'(ha.pop_back());
         void'(hb.pop_back());
      end
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_min(input int got, input int lim);
      num_checks++;
      if (got < lim)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, lim);
      end
   endtask

   // output must copy the active source a few samples back
   task automatic follow(input int n);
      int q[$];
      bit ok;
      repeat (n)
      begin
         @(posedge mclk);
         #1;
         q = (active_select === 1'b1) ? hb : ha;
         ok = 0;
         for (int k = 3; k <= 6; k++)
            ok |= (clock_out === logic'(q[k][0]));
         check_bit(ok, 1'b1);
      end
   endtask

   // staged switch; random phase of select against both sources
   task automatic do_switch(input logic to_b, input logic stuck);
      int t, post, run, edges, low_max, run_min, tper, lim, t_done;
      logic prev;
      bit done, saw_busy;
      tper = to_b ? 12 : 10;
      lim = 19 * tper + 16;
      t = 0;
      post = 0;
      run = 0;
      edges = 0;
      low_max = 0;
      t_done = 0;
      done = 0;
      saw_busy = 0;
      run_min = 99;
      repeat ($urandom_range(1, 9)) @(posedge mclk);
      sel <= to_b;
      // let the launching edge settle before taking the start level
      #1;
      prev = clock_out;
      while (t < lim && post < 2 * tper)
      begin
         @(posedge mclk);
         #1;
         t++;
         if (busy === 1'b1 && !saw_busy && stuck)
            check_bit(clock_out, 1'b1);
         if (busy === 1'b1)
            saw_busy = 1;
         if (done)
            post++;
         else if (t > 1 && active_select === to_b && busy === 1'b0)
         begin
            done = 1;
            t_done = t;
         end
         if (clock_out !== prev)
         begin
            if (edges > 0 && run < run_min)
               run_min = run;
            if (edges > 0 && prev === 1'b0 && run > low_max)
               low_max = run;
            edges++;
            run = 0;
            prev = clock_out;
         end
         run++;
      end
      check_bit(done, 1'b1);
      check_min(clock_mux_pkg::SWITCH_MAX_EDGES * tper - t_done, 0);
      check_bit(saw_busy, 1'b1);
      check_min(run_min, 4);
      check_min(low_max, tper / 2 + 1);
   endtask

   // protection off: select acts at once, never busy
   task automatic bypass(input logic to_b);
      int t;
      t = 0;
      repeat ($urandom_range(1, 9)) @(posedge mclk);
      sel <= to_b;
      #1;
      while (active_select !== to_b && t < 10)
      begin
         @(posedge mclk);
         #1;
         t++;
         check_bit(busy, 1'b0);
      end
      check_bit(active_select, to_b);
      follow(30);
   endtask

   // loss flag of the active source freezes the output, then releases
   task automatic loss_hold(input logic on_b);
      logic frozen_now;
      @(posedge mclk);
      if (on_b)
         lost_b <= 1'b1;
      else
         lost_a <= 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      check_bit(hold, 1'b1);
      frozen_now = clock_out;
      repeat (30)
      begin
         @(posedge mclk);
         #1;
         check_bit(clock_out, frozen_now);
      end
      @(posedge mclk);
      lost_a <= 1'b0;
      lost_b <= 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      check_bit(hold, 1'b0);
      follow(40);
   endtask

   // main sequence
   initial
   begin
      void'($urandom(32'hF497));
      rstn = 1'b0;
      stuck_a = 1'b0;
      lost_a = 1'b0;
      lost_b = 1'b0;
      sel = 1'b0;
      strap = 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      check_bit(clock_out, 1'b0);
      check_bit(glitchless_switch, 1'b0);
      @(posedge mclk);
      rstn <= 1'b1;
      repeat (12) @(posedge mclk);
      #1;
      check_bit(glitchless_switch, 1'b1);
      check_bit(active_select, 1'b0);
      follow(40);
      do_switch(1'b1, 1'b0);
      follow(40);
      do_switch(1'b0, 1'b0);
      follow(40);
      loss_hold(1'b0);
      @(posedge mclk);
      stuck_a <= 1'b1;
      repeat (20) @(posedge mclk);
      do_switch(1'b1, 1'b1);
      follow(40);
      loss_hold(1'b1);
      @(posedge mclk);
      stuck_a <= 1'b0;
      do_switch(1'b0, 1'b0);
      @(posedge mclk);
      strap <= 1'b1;
      repeat (10) @(posedge mclk);
      #1;
      check_bit(glitchless_switch, 1'b0);
      bypass(1'b1);
      bypass(1'b0);
      end_of_test();
   end
endmodule // tb_top
